// ==== cpflow_pkg.sv ====
`default_nettype none
package cpflow_pkg;
    // register byte offsets
    localparam logic [4:0] ADR_CTRL = 5'h00;
    localparam logic [4:0] ADR_ERR = 5'h04;
    localparam logic [4:0] ADR_STAT = 5'h08;
    localparam logic [4:0] ADR_CNT = 5'h0c;
    localparam logic [4:0] ADR_BASE = 5'h10;
    // control register fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_RCB = 1;
    localparam int CTRL_MODEL = 2;
    localparam int CTRL_LOCK = 4;
    localparam int CTRL_RUN = 5;
    // error status fields
    localparam int ES_DIS = 0;
    localparam int ES_ILL = 1;
    // channel status and counter register fields
    localparam int ST_Z = 0;
    localparam int ST_N = 1;
    localparam int ST_IEN = 2;
    localparam int ST_CEN = 3;
    localparam int ST_DATA_POINTER_FIELD = 8;
    localparam int CNT_SERVICE_PRIORITY_NUMBER = 16;
    // context strides per model
    localparam logic [7:0] STRIDE_FULL = 8'h20;
    localparam logic [7:0] STRIDE_SMALL = 8'h10;
    localparam logic [7:0] STRIDE_MIN = 8'h08;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;

    typedef enum logic [2:0] {
        OP_NOP = 3'b000, OP_JIND = 3'b001, OP_JIDX = 3'b010,
        OP_COPY = 3'b011, OP_BURST_COPY = 3'b100, OP_EXIT = 3'b101,
        OP_WSTAT = 3'b110, OP_PMEM = 3'b111
    } op_t;
    typedef enum logic [1:0] {
        MOD_KEEP = 2'b00, MOD_INC = 2'b01, MOD_DEC = 2'b10
    } mod_t;
    typedef enum logic [1:0] {
        MODEL_FULL = 2'b00, MODEL_SMALL = 2'b01, MODEL_MIN = 2'b10
    } model_t;

    typedef struct packed {
        op_t op;
        logic cond;
        logic [31:0] val;
        logic [31:0] src;
        logic [31:0] dst;
        mod_t smod;
        mod_t dmod;
        logic [3:0] cnt;
        logic ep;
        logic cnz;
        logic [1:0] flags;
        logic [5:0] off;
    } instr_t;
    typedef struct packed {
        logic [7:0] service_priority_number;
        logic channel_enable_bit;
        logic [15:0] pc;
    } invoke_t;
    typedef struct packed {
        logic req;
        logic we;
        logic lock;
        logic [3:0] burst;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;
endpackage
`default_nettype wire

// ==== channel_flow_copy.sv ====
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module channel_flow_copy (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic [4:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // system state
    input wire logic global_init_done_i,
    // channel invocation
    input wire logic inv_valid_i,
    input wire cpflow_pkg::invoke_t inv_i,
    output logic inv_ready_o,
    // instruction issue
    input wire logic ins_valid_i,
    input wire cpflow_pkg::instr_t ins_i,
    output logic ins_ready_o,
    // system bus master
    output cpflow_pkg::mem_req_t mem_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    // results
    output logic [15:0] pc_o,
    output logic [15:0] ctx_addr_o,
    output logic [15:0] saved_pc_o,
    output logic [13:0] pmem_addr_o,
    output logic [31:0] src_o,
    output logic [31:0] dst_o,
    output logic int_allowed_o,
    output logic exit_irq_o,
    output logic [7:0] exit_service_priority_number_o,
    output logic err_irq_o
);
    import cpflow_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00, S_READ = 2'b01, S_WRITE = 2'b10
    } fsm_t;

    typedef struct packed {
        fsm_t st;
        logic en;
        logic restart_from_base_bit;
        model_t model;
        logic lock;
        logic [1:0] es;
        logic [15:0] stat;
        logic [15:0] tc;
        logic [7:0] service_priority_number;
        logic [15:0] pbase;
        logic act;
        logic [7:0] chan;
        logic [15:0] pc;
        logic [15:0] ctx;
        logic [15:0] saved;
        logic [13:0] paddr;
        logic ien_eff;
        logic [31:0] src;
        logic [31:0] dst;
        mod_t smod;
        mod_t dmod;
        logic [4:0] left;
        logic [3:0] chunk;
        logic [3:0] idx;
        logic [7:0][31:0] buffer;
        mem_req_t mem;
        logic ack;
        logic err;
        logic [31:0] rdat;
        logic xirq;
        logic [7:0] xsrpn;
        logic eirq;
        logic ins_rdy;
        logic inv_rdy;
    } state_t;

    state_t s;
    state_t n;
    logic wb_go;
    logic ins_go;
    logic inv_go;
    logic [31:0] wv;
    logic [3:0] bw;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0] b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] step(input logic [31:0] p,
                                         input mod_t m);
        case (m)
        MOD_INC: step = p + WORD_STEP;
        MOD_DEC: step = p - WORD_STEP;
        default: step = p;
        endcase
    endfunction

    function automatic logic aligned(input logic [31:0] a,
                                     input logic [3:0] w);
        logic [31:0] m;
        m = ({28'h000_0000, w} << 2) - 32'h0000_0001;
        return (a & m) == 32'h0000_0000;
    endfunction

    function automatic logic [7:0] stride(input model_t m);
        case (m)
        MODEL_SMALL: stride = STRIDE_SMALL;
        MODEL_MIN: stride = STRIDE_MIN;
        default: stride = STRIDE_FULL;
        endcase
    endfunction

    function automatic logic [3:0] burst_words(input logic [3:0] c);
        case (c)
        4'h1: burst_words = 4'h2;
        4'h2: burst_words = 4'h4;
        4'h3: burst_words = 4'h8;
        default: burst_words = 4'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = s;
        n.ack = 1'b0;
        n.err = 1'b0;
        n.xirq = 1'b0;
        n.eirq = 1'b0;
        wv = 32'h0000_0000;
        bw = 4'h0;
        wb_go = cyc_i && stb_i && !s.ack && !s.err;
        ins_go = ins_valid_i && s.ins_rdy;
        inv_go = inv_valid_i && s.inv_rdy;
        // register access first, so hardware events below win over clears
        if (wb_go) begin
            n.ack = 1'b1;
            n.rdat = 32'h0000_0000;
            case (adr_i)
            ADR_CTRL: begin
                n.rdat[CTRL_EN] = s.en;
                n.rdat[CTRL_RCB] = s.restart_from_base_bit;
                n.rdat[CTRL_MODEL +: 2] = s.model;
                n.rdat[CTRL_LOCK] = s.lock;
                n.rdat[CTRL_RUN] = s.act || (s.st != S_IDLE);
                if (we_i && s.lock && global_init_done_i) begin
                    n.ack = 1'b0;
                    n.err = 1'b1;
                end else if (we_i) begin
                    wv = merge(n.rdat, dat_i, sel_i);
                    n.en = wv[CTRL_EN];
                    n.restart_from_base_bit = wv[CTRL_RCB];
                    n.model = model_t'(wv[CTRL_MODEL +: 2]);
                    n.lock = wv[CTRL_LOCK];
                end
            end
            ADR_ERR: begin
                n.rdat[1:0] = s.es;
                if (we_i && sel_i[0]) begin
                    n.es = s.es & ~dat_i[1:0];
                end
            end
            ADR_STAT: begin
                n.rdat[15:0] = s.stat;
                if (we_i) begin
                    wv = merge({16'h0000, s.stat}, dat_i, sel_i);
                    n.stat = wv[15:0];
                end
            end
            ADR_CNT: begin
                n.rdat = {8'h00, s.service_priority_number, s.tc};
                if (we_i) begin
                    wv = merge(n.rdat, dat_i, sel_i);
                    n.tc = wv[15:0];
                    n.service_priority_number = wv[CNT_SERVICE_PRIORITY_NUMBER +: 8];
                end
            end
            ADR_BASE: begin
                n.rdat[15:0] = s.pbase;
                if (we_i) begin
                    wv = merge(n.rdat, dat_i, sel_i);
                    n.pbase = wv[15:0];
                end
            end
            default: begin
                n.ack = 1'b0;
                n.err = 1'b1;
            end
            endcase
        end
        if (inv_go && inv_i.service_priority_number != 8'h00) begin
            n.ctx = 16'(s.pbase + 16'(inv_i.service_priority_number) * 16'(stride(s.model)));
            n.stat[ST_CEN] = inv_i.channel_enable_bit;
            if (!inv_i.channel_enable_bit) begin
                n.es[ES_DIS] = 1'b1;
                n.eirq = 1'b1;
            end else begin
                n.act = 1'b1;
                n.chan = inv_i.service_priority_number;
                n.pc = s.restart_from_base_bit ? {8'h00, inv_i.service_priority_number} : inv_i.pc;
            end
        end
        if (ins_go) begin
            n.pc = s.pc + 16'h0001;
            n.ien_eff = s.stat[ST_IEN];
            case (ins_i.op)
            OP_JIND: begin
                n.pc = ins_i.val[15:0];
            end
            OP_JIDX: begin
                if (ins_i.cond) begin
                    n.pc = s.pc + 16'h0001 + ins_i.val[15:0];
                end
            end
            OP_COPY, OP_BURST_COPY: begin
                n.src = ins_i.src;
                n.dst = ins_i.dst;
                n.smod = ins_i.smod;
                n.dmod = ins_i.dmod;
                n.idx = 4'h0;
                bw = (ins_i.op == OP_BURST_COPY) ? burst_words(ins_i.cnt)
                                            : ins_i.cnt;
                n.chunk = (ins_i.op == OP_BURST_COPY) ? bw : 4'h1;
                n.left = {1'b0, bw};
                if (bw == 4'h0 || (ins_i.op == OP_BURST_COPY &&
                    !(aligned(ins_i.src, bw) && aligned(ins_i.dst, bw)))) begin
                    n.es[ES_ILL] = 1'b1;
                    n.eirq = 1'b1;
                    n.act = 1'b0;
                end else begin
                    n.st = S_READ;
                    n.mem.req = 1'b1;
                    n.mem.we = 1'b0;
                    n.mem.lock = 1'b1;
                    n.mem.burst = n.chunk;
                    n.mem.addr = ins_i.src;
                end
            end
            OP_EXIT: begin
                if (ins_i.cnz && s.tc == 16'h0000) begin
                    n.xirq = 1'b1;
                    n.xsrpn = s.service_priority_number;
                end
                n.saved = ins_i.ep ? s.pc + 16'h0001 : {8'h00, s.chan};
                n.act = 1'b0;
            end
            OP_WSTAT: begin
                n.stat = ins_i.val[15:0];
                n.stat[ST_N:ST_Z] = ins_i.flags;
            end
            OP_PMEM: begin
                n.paddr = {s.stat[ST_DATA_POINTER_FIELD +: 8], ins_i.off};
            end
            default: begin
            end
            endcase
        end
        case (s.st)
        S_READ: begin
            if (mem_ack_i) begin
                n.buffer[s.idx[2:0]] = mem_rdata_i;
                n.src = step(s.src, s.smod);
                if (s.idx == s.chunk - 4'h1) begin
                    n.idx = 4'h0;
                    n.st = S_WRITE;
                    n.mem.we = 1'b1;
                    n.mem.addr = s.dst;
                    n.mem.wdata = (s.idx == 4'h0) ? mem_rdata_i
                                                  : s.buffer[0];
                end else begin
                    n.idx = s.idx + 4'h1;
                    n.mem.addr = n.src;
                end
            end
        end
        S_WRITE: begin
            if (mem_ack_i) begin
                n.dst = step(s.dst, s.dmod);
                if (s.idx == s.chunk - 4'h1) begin
                    n.idx = 4'h0;
                    n.left = s.left - {1'b0, s.chunk};
                    if (n.left == 5'h00) begin
                        n.tc = s.tc - 16'h0001;
                        n.st = S_IDLE;
                        n.mem = '0;
                    end else begin
                        n.st = S_READ;
                        n.mem.we = 1'b0;
                        n.mem.addr = n.src;
                    end
                end else begin
                    n.idx = s.idx + 4'h1;
                    n.mem.addr = n.dst;
                    n.mem.wdata = s.buffer[n.idx[2:0]];
                end
            end
        end
        default: begin
        end
        endcase
        n.ins_rdy = (n.st == S_IDLE) && n.act && n.en;
        n.inv_rdy = (n.st == S_IDLE) && !n.act && n.en && !inv_go;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= n;
        end
    end

    assign dat_o = s.rdat;
    assign ack_o = s.ack;
    assign err_o = s.err;
    assign inv_ready_o = s.inv_rdy;
    assign ins_ready_o = s.ins_rdy;
    assign mem_o = s.mem;
    assign pc_o = s.pc;
    assign ctx_addr_o = s.ctx;
    assign saved_pc_o = s.saved;
    assign pmem_addr_o = s.paddr;
    assign src_o = s.src;
    assign dst_o = s.dst;
    assign int_allowed_o = s.ien_eff;
    assign exit_irq_o = s.xirq;
    assign exit_service_priority_number_o = s.xsrpn;
    assign err_irq_o = s.eirq;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence ctrl_write_locked;
        wb_go && ce_i && we_i && adr_i == ADR_CTRL && s.lock &&
            global_init_done_i;
    endsequence

    chk_indirect_pc: assert property (
        ins_go && ce_i && ins_i.op == OP_JIND |=> pc_o == $past(ins_i.val[15:0]))
        else $error("indirect jump pc wrong");
    chk_indexed_pc: assert property (
        ins_go && ce_i && ins_i.op == OP_JIDX |=> pc_o == $past(s.pc) + 16'h0001 +
            ($past(ins_i.cond) ? $past(ins_i.val[15:0]) : 16'h0000))
        else $error("indexed jump pc wrong");
    chk_copy_count: assert property (
        s.st == S_WRITE && n.st == S_IDLE && ce_i |=> s.tc == $past(s.tc) - 16'h0001)
        else $error("transfer counter not decremented");
    chk_exit_irq: assert property (
        ins_go && ce_i && ins_i.op == OP_EXIT && ins_i.cnz && s.tc == 16'h0000
            |=> exit_irq_o && exit_service_priority_number_o == $past(s.service_priority_number))
        else $error("counter exit interrupt missing");
    chk_bus_lock: assert property (
        s.st != S_IDLE |-> mem_o.lock && mem_o.req)
        else $error("bus not locked during copy");
    chk_burst_align: assert property (
        ins_go && ce_i && ins_i.op == OP_BURST_COPY && burst_words(ins_i.cnt) != 4'h0 &&
            !aligned(ins_i.src, burst_words(ins_i.cnt)) |=> err_irq_o && s.es[ES_ILL]
            && s.st == S_IDLE)
        else $error("misaligned burst not refused");
    chk_disabled_chan: assert property (
        inv_go && ce_i && !inv_i.channel_enable_bit && inv_i.service_priority_number != 8'h00
            |=> err_irq_o && s.es[ES_DIS] && !ins_ready_o)
        else $error("disabled channel not reported");
    chk_ctrl_locked: assert property (
        ctrl_write_locked |=> err_o && !ack_o ##1 !err_o)
        else $error("locked control write not refused");
    chk_start_pc: assert property (
        inv_go && ce_i && inv_i.channel_enable_bit && inv_i.service_priority_number != 8'h00 |=> pc_o ==
            ($past(s.restart_from_base_bit) ? {8'h00, $past(inv_i.service_priority_number)} : $past(inv_i.pc)))
        else $error("channel start pc wrong");
    chk_ien_delay: assert property (
        ins_go && ce_i |=> int_allowed_o == $past(s.stat[ST_IEN]))
        else $error("interrupt enable delay wrong");
endmodule // channel_flow_copy
`default_nettype wire

// ==== sysbus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sysbus_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus from the block
    input wire cpflow_pkg::mem_req_t mem_i,
    input wire logic [3:0] lat_i,
    output logic ack_o,
    output logic [31:0] rdata_o,
    // observation
    output logic [15:0] beats_o,
    output logic lock_bad_o
);
    import cpflow_pkg::*;
    logic [31:0] mem [0:8191];
    logic [3:0] wait_c;
    logic [3:0] bc;
    logic [31:0] base;
    logic rd_locked;
    logic [31:0] ea;
    // later beats follow the first address of the chunk
    assign ea = (bc == 4'h0) ? mem_i.addr : base + {26'h0, bc, 2'b00};
    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = 32'hA500_0000 + 32'(i);
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            rdata_o <= 32'h5A5A_0F0F;
            {wait_c, bc, beats_o, lock_bad_o, rd_locked} <= '0;
        end else begin
            ack_o <= 1'b0;
            // no valid data: toggle so stale values match only every second cycle
            rdata_o <= ~rdata_o;
            if (!mem_i.lock) rd_locked <= 1'b0;
            if (mem_i.req && !ack_o) begin
                if (wait_c < lat_i) begin
                    wait_c <= wait_c + 4'h1;
                end else begin
                    wait_c <= 4'h0;
                    ack_o <= 1'b1;
                    beats_o <= beats_o + 16'h0001;
                    if (bc == 4'h0) base <= mem_i.addr;
                    bc <= (bc + 4'h1 >= mem_i.burst) ? 4'h0 : bc + 4'h1;
                    if (mem_i.we) begin
                        mem[ea[14:2]] <= mem_i.wdata;
                        if (!rd_locked) lock_bad_o <= 1'b1;
                    end else begin
                        rdata_o <= mem[ea[14:2]];
                        rd_locked <= mem_i.lock;
                    end
                end
            end
        end
    end
endmodule // sysbus_model
`default_nettype wire

// ==== channel_flow_copy_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module channel_flow_copy_tb;
    import cpflow_pkg::*;
    typedef struct packed {
        model_t model; logic restart_from_base_bit; logic [7:0] service_priority_number; logic [15:0] pc;
        logic ep; logic [15:0] ctx; logic [15:0] xpc; logic [15:0] spc;
    } row_t;
    logic clk_i, rst_i, ce, cyc, stb, we, inv_valid, ins_valid, gdone, e;
    logic [4:0] adr;
    logic [31:0] wdat, dat_o, mem_rdata, src_o, dst_o, q;
    invoke_t inv;
    instr_t ins, ir;
    mem_req_t mem;
    logic [3:0] lat;
    logic ack_o, err_o, inv_ready_o, ins_ready_o, int_allowed_o;
    logic exit_irq_o, err_irq_o, mem_ack, lock_bad;
    logic [15:0] pc_o, ctx_addr_o, saved_pc_o, beats;
    logic [13:0] pmem_addr_o;
    logic [7:0] exit_service_priority_number_o;
    int n_mismatch = 0, total_checks = 0, n_exit = 0, n_err = 0, n;
    row_t rows [3];
    ////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    channel_flow_copy DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .adr_i(adr), .dat_i(wdat), .sel_i(4'hF), .we_i(we), .cyc_i(cyc),
        .stb_i(stb), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .global_init_done_i(gdone), .inv_valid_i(inv_valid), .inv_i(inv),
        .inv_ready_o(inv_ready_o), .ins_valid_i(ins_valid), .ins_i(ins),
        .ins_ready_o(ins_ready_o), .mem_o(mem), .mem_ack_i(mem_ack),
        .mem_rdata_i(mem_rdata), .pc_o(pc_o), .ctx_addr_o(ctx_addr_o),
        .saved_pc_o(saved_pc_o), .pmem_addr_o(pmem_addr_o), .src_o(src_o),
        .dst_o(dst_o), .int_allowed_o(int_allowed_o),
        .exit_irq_o(exit_irq_o), .exit_service_priority_number_o(exit_service_priority_number_o),
        .err_irq_o(err_irq_o));
    sysbus_model bus (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem), .lat_i(lat),
        .ack_o(mem_ack), .rdata_o(mem_rdata), .beats_o(beats),
        .lock_bad_o(lock_bad));
    // pulses are counted so a test can look at them later
    always @(posedge clk_i) begin
        if (exit_irq_o === 1'b1) n_exit <= n_exit + 1;
        if (err_irq_o === 1'b1) n_err <= n_err + 1;
    end
    ////////////////////////////////////////
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            $display("wrong value %s expected %h seen %h", nm, x, g);
            n_mismatch++;
        end
    endtask
    task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        k = 0;
        do begin @(posedge clk_i); k++; end
        while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 50);
        if (ack_o !== 1'b1 && err_o !== 1'b1) n_mismatch++;
        q = dat_o;
        e = err_o;
        {cyc, stb} <= 2'b00;
    endtask
    task inv_go(input logic [7:0] s, input logic c, input logic [15:0] p);
        int k;
        @(posedge clk_i);
        inv_valid <= 1'b1;
        inv <= {s, c, p};
        k = 0;
        do begin @(posedge clk_i); k++; end
        while (inv_ready_o !== 1'b1 && k < 50);
        if (inv_ready_o !== 1'b1) n_mismatch++;
        inv_valid <= 1'b0;
        @(posedge clk_i);
    endtask
    // ends at the first edge where the result shows and the bus is idle;
    // exits and refused copies never bring ready back, so it is not awaited
    task exe(input instr_t i);
        int k;
        @(posedge clk_i);
        ins_valid <= 1'b1;
        ins <= i;
        k = 0;
        do begin @(posedge clk_i); k++; end
        while (ins_ready_o !== 1'b1 && k < 50);
        if (ins_ready_o !== 1'b1) n_mismatch++;
        ins_valid <= 1'b0;
        k = 0;
        do begin @(posedge clk_i); k++; end
        while (mem.req === 1'b1 && k < 100);
        if (mem.req === 1'b1) n_mismatch++;
    endtask
    function automatic instr_t mk(input op_t o, input logic [31:0] v);
        mk = '0;
        mk.op = o;
        mk.cond = 1'b1;
        mk.val = v;
    endfunction
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        test_done();
    end
    initial begin
        rows[0] = {MODEL_FULL, 1'b0, 8'h03, 16'h0040, 1'b0, 16'h0160,
            16'h0040, 16'h0003};
        rows[1] = {MODEL_SMALL, 1'b0, 8'h05, 16'h0050, 1'b1, 16'h0150,
            16'h0050, 16'h0051};
        rows[2] = {MODEL_MIN, 1'b1, 8'h07, 16'h0060, 1'b0, 16'h0138,
            16'h0007, 16'h0007};
        {rst_i, ce, cyc, stb, we, inv_valid, ins_valid, gdone} = 8'b1100_0000;
        {adr, wdat, inv, ins, lat} = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, ADR_BASE, 32'h0000_0100);
        for (int r = 0; r < 3; r++) begin
            wb(1'b1, ADR_CTRL, 32'h0000_0000);
            wb(1'b1, ADR_CTRL, {28'h0, rows[r].model, rows[r].restart_from_base_bit, 1'b1});
            inv_go(rows[r].service_priority_number, 1'b1, rows[r].pc);
            chk("context address", 32'(rows[r].ctx), 32'(ctx_addr_o));
            chk("start pc", 32'(rows[r].xpc), 32'(pc_o));
            ir = mk(OP_EXIT, 32'h0000_0000);
            ir.ep = rows[r].ep;
            exe(ir);
            repeat (2) @(posedge clk_i);
            chk("saved pc", 32'(rows[r].spc), 32'(saved_pc_o));
        end
        $display("context rows done");
        @(posedge clk_i);
        inv_valid <= 1'b1;
        inv <= {8'h00, 1'b1, 16'h0077};
        repeat (4) @(posedge clk_i);
        inv_valid <= 1'b0;
        @(posedge clk_i);
        chk("zero priority ctx", 32'h0000_0138, 32'(ctx_addr_o));
        chk("zero priority run", 32'h0000_0000, 32'(ins_ready_o));
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        wb(1'b1, ADR_CNT, 32'h0003_0002);
        wb(1'b1, ADR_CTRL, 32'h0000_0001);
        inv_go(8'h03, 1'b1, 16'h0040);
        exe(mk(OP_JIND, 32'h0000_0123));
        chk("indirect jump", 32'h0000_0123, 32'(pc_o));
        exe(mk(OP_JIDX, 32'h0000_0005));
        chk("indexed jump", 32'h0000_0129, 32'(pc_o));
        ir = mk(OP_JIDX, 32'h0000_0005);
        ir.cond = 1'b0;
        exe(ir);
        chk("false condition", 32'h0000_012A, 32'(pc_o));
        exe(mk(OP_JIDX, 32'h0000_0000));
        chk("zero index", 32'h0000_012B, 32'(pc_o));
        ir = mk(OP_WSTAT, 32'hFFFF_020C);
        ir.flags = 2'b11;
        exe(ir);
        exe(mk(OP_NOP, 32'h0000_0000));
        chk("ien set", 32'h0000_0001, 32'(int_allowed_o));
        wb(1'b1, ADR_STAT, 32'hFFFF_020F);
        chk("status upper write err", 32'h0000_0000, 32'(e));
        wb(1'b0, ADR_STAT, 32'h0000_0000);
        chk("status", 32'h0000_020F, q);
        exe(mk(OP_WSTAT, 32'h0000_0208));
        chk("ien delayed", 32'h0000_0001, 32'(int_allowed_o));
        exe(mk(OP_NOP, 32'h0000_0000));
        chk("ien cleared", 32'h0000_0000, 32'(int_allowed_o));
        ir = mk(OP_PMEM, 32'h0000_0000);
        ir.off = 6'h05;
        exe(ir);
        chk("pmem address", 32'h0000_0085, 32'(pmem_addr_o));
        $display("flow test done");
        lat <= 4'h3;
        n = beats;
        ir = mk(OP_COPY, 32'h0000_0000);
        {ir.src, ir.dst} = {32'h0000_1000, 32'h0000_2000};
        ir.smod = MOD_INC;
        ir.dmod = MOD_DEC;
        ir.cnt = 4'h2;
        exe(ir);
        chk("copy beats", 32'(n + 4), 32'(beats));
        chk("copy word0", 32'hA500_0400, bus.mem[13'h0800]);
        chk("copy word1", 32'hA500_0401, bus.mem[13'h07FF]);
        chk("source ptr", 32'h0000_1008, src_o);
        chk("dest ptr", 32'h0000_1FF8, dst_o);
        wb(1'b0, ADR_CNT, 32'h0000_0000);
        chk("counter", 32'h0000_0001, {16'h0000, q[15:0]});
        exe(ir);
        n = n_exit;
        ir = mk(OP_EXIT, 32'h0000_0000);
        {ir.cnz, ir.ep} = 2'b11;
        exe(ir);
        repeat (2) @(posedge clk_i);
        chk("exit irq", 32'(n + 1), 32'(n_exit));
        chk("exit priority", 32'h0000_0003, 32'(exit_service_priority_number_o));
        $display("copy test done");
        lat <= 4'h0;
        inv_go(8'h03, 1'b1, 16'h0040);
        for (int c = 1; c < 4; c++) begin
            n = beats;
            ir = mk(OP_BURST_COPY, 32'h0000_0000);
            {ir.src, ir.dst} = {32'h0000_3000, 32'h0000_4000};
            ir.smod = MOD_KEEP;
            ir.dmod = MOD_KEEP;
            ir.cnt = 4'(c);
            exe(ir);
            chk("burst beats", 32'(n + (4 << (c - 1))), 32'(beats));
        end
        for (int k = 0; k < 8; k++)
            chk("burst word", 32'hA500_0C00 + 32'(k), bus.mem[13'h1000 + 13'(k)]);
        chk("lock held", 32'h0000_0000, 32'(lock_bad));
        n = n_err;
        ir.src = 32'h0000_3008;
        ir.cnt = 4'h2;
        exe(ir);
        repeat (2) @(posedge clk_i);
        chk("align error irq", 32'(n + 1), 32'(n_err));
        wb(1'b0, ADR_ERR, 32'h0000_0000);
        chk("illegal cause", 32'h0000_0002, q);
        inv_go(8'h03, 1'b0, 16'h0040);
        repeat (2) @(posedge clk_i);
        chk("disabled irq", 32'(n + 2), 32'(n_err));
        chk("halted", 32'h0000_0000, 32'(ins_ready_o));
        wb(1'b0, ADR_ERR, 32'h0000_0000);
        chk("disabled cause", 32'h0000_0003, q);
        wb(1'b1, ADR_ERR, 32'h0000_0003);
        wb(1'b0, ADR_ERR, 32'h0000_0000);
        chk("cause cleared", 32'h0000_0000, q);
        $display("burst and error test done");
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
        // clock enable low: a pending access must stay unanswered
        @(posedge clk_i);
        ce <= 1'b0;
        {cyc, stb, we, adr, wdat} <= {3'b111, ADR_BASE, 32'h0000_0055};
        repeat (4) @(posedge clk_i);
        chk("frozen ack", 32'h0000_0000, 32'(ack_o));
        ce <= 1'b1;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        {cyc, stb} <= 2'b00;
        wb(1'b0, ADR_BASE, 32'h0000_0000);
        chk("base after freeze", 32'h0000_0055, q);
        wb(1'b1, ADR_CTRL, 32'h0000_0010);
        gdone <= 1'b1;
        wb(1'b1, ADR_CTRL, 32'h0000_0011);
        chk("locked write", 32'h0000_0001, 32'(e));
        wb(1'b0, ADR_CTRL, 32'h0000_0000);
        chk("control kept", 32'h0000_0010, q);
        wb(1'b0, 5'h14, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, 32'(e));
        $display("lock test done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 5; a++) begin
            wb(1'b0, 5'(a * 4), 32'h0000_0000);
            chk("reset value", 32'h0000_0000, q);
        end
        $display("reset test done");
        test_done();
    end
endmodule // channel_flow_copy_tb
`default_nettype wire
